// ---- core/prs_regs.svh ----
// register offsets, field positions, reset values and vectors for the program counter unit
`ifndef PRS_REGS_SVH
`define PRS_REGS_SVH

// byte offsets on the register bus
`define PRS_OFS_PC_LOW 12'h000
`define PRS_OFS_PC_HIGH_LATCH 12'h004
`define PRS_OFS_PC_UPPER_LATCH 12'h008
`define PRS_OFS_STACK_PTR 12'h00C
`define PRS_OFS_STACK_TOP_LOW 12'h010
`define PRS_OFS_STACK_TOP_HIGH 12'h014
`define PRS_OFS_STACK_TOP_UPPER 12'h018
`define PRS_OFS_CONTROL 12'h01C

// pointer register fields
`define PRS_PTR_FULL_BIT 7
`define PRS_PTR_UNDERFLOW_BIT 6
`define PRS_PTR_INDEX_MSB 4

// control register fields and reset value
`define PRS_CTRL_FAULT_RESET_BIT 0
`define PRS_CTRL_RESET 1'h1

// fixed vectors
`define PRS_VEC_RESET 21'h000000
`define PRS_VEC_INT_HIGH 21'h000008
`define PRS_VEC_INT_LOW 21'h000018

// counter geometry
`define PRS_PC_WIDTH 21
`define PRS_PC_STEP 21'h000002
`define PRS_STACK_DEPTH 31

`endif

// ---- core/prs_pkg.sv ----
// types shared by the program counter unit
`default_nettype none
package prs_pkg;
    typedef enum logic [3:0] {
        PRS_OP_NONE,
        PRS_OP_SEQ,
        PRS_OP_JUMP,
        PRS_OP_CALL,
        PRS_OP_RETURN,
        PRS_OP_RET_LITERAL,
        PRS_OP_RET_INTERRUPT,
        PRS_OP_INT_HIGH,
        PRS_OP_INT_LOW,
        PRS_OP_PUSH,
        PRS_OP_POP
    } prs_op_t;

    typedef logic [20:0] prs_addr_t;
endpackage
`default_nettype wire

// ---- core/prs_stack_if.sv ----
// carrier between the counter logic and the return stack
`default_nettype none
interface prs_stack_if;
    import prs_pkg::*;
    logic push;
    logic pop;
    logic discard;
    prs_addr_t push_data;
    logic [2:0] tos_we;
    logic [7:0] tos_wdata;
    logic ptr_we;
    logic [7:0] ptr_wdata;
    logic fault_en;
    logic [4:0] ptr;
    logic full;
    logic underflow;
    prs_addr_t stack_top_entry;
    logic fault;

    modport ctl (
        output push, pop, discard, push_data, tos_we, tos_wdata, ptr_we, ptr_wdata, fault_en,
        input ptr, full, underflow, stack_top_entry, fault
    );
    modport stk (
        input push, pop, discard, push_data, tos_we, tos_wdata, ptr_we, ptr_wdata, fault_en,
        output ptr, full, underflow, stack_top_entry, fault
    );
endinterface
`default_nettype wire

// ---- core/prs_stack.sv ----
// return address stack: storage, pointer and fault flags
`include "prs_regs.svh"
`default_nettype none
module prs_stack
    import prs_pkg::*;
#(
    parameter int DEPTH = `PRS_STACK_DEPTH
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control side
    prs_stack_if.stk sif
);
    // --------
    // state
    // --------
    prs_addr_t mem [1:DEPTH];
    logic [4:0] ptr;
    logic full;
    logic underflow;
    logic at_top;
    logic at_empty;
    logic any_pop;
    logic set_full;
    logic set_unf;

    localparam logic [4:0] TOP_IDX = 5'(DEPTH);
    localparam logic [4:0] LAST_FREE = 5'(DEPTH - 1);

    assign at_top = (ptr == TOP_IDX);
    assign at_empty = (ptr == 5'h00);
    assign any_pop = sif.pop | sif.discard;
    assign set_full = sif.push & (ptr >= LAST_FREE);
    assign set_unf = any_pop & at_empty;
    assign sif.fault = sif.fault_en & (set_full | set_unf);
    assign sif.ptr = ptr;
    assign sif.full = full;
    assign sif.underflow = underflow;
    // index zero has no storage and reads as zero, which gives the underflow value
    assign sif.stack_top_entry = at_empty ? 21'h000000 : mem[ptr];

    // --------
    // pointer
    // --------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ptr <= 5'h00;
        else if (sif.fault)
            ptr <= 5'h00;
        else if (sif.push)
        begin
            if (!at_top)
                ptr <= ptr + 5'h01;
        end
        else if (any_pop)
        begin
            if (!at_empty)
                ptr <= ptr - 5'h01;
        end
        else if (sif.ptr_we)
            ptr <= sif.ptr_wdata[`PRS_PTR_INDEX_MSB:0];
    end

    // --------
    // flags: set wins over a software clear
    // --------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            full <= 1'b0;
        else
            full <= set_full | (full & ~(sif.ptr_we & ~sif.ptr_wdata[`PRS_PTR_FULL_BIT]));
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            underflow <= 1'b0;
        else
            underflow <= set_unf | (underflow & ~(sif.ptr_we & ~sif.ptr_wdata[`PRS_PTR_UNDERFLOW_BIT]));
    end

    // --------
    // storage entries
    // --------
    for (genvar i = 1; i <= DEPTH; i++)
    begin : g_entry
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                mem[i] <= 21'h000000;
            else if (sif.push & !at_top & (ptr + 5'h01 == 5'(i)))
                mem[i] <= sif.push_data;
            else if (!sif.push & (ptr == 5'(i)))
            begin
                if (sif.tos_we[0])
                    mem[i][7:0] <= sif.tos_wdata;
                if (sif.tos_we[1])
                    mem[i][15:8] <= sif.tos_wdata;
                if (sif.tos_we[2])
                    mem[i][20:16] <= sif.tos_wdata[4:0];
            end
        end
    end
endmodule
`default_nettype wire

// ---- core/prs_top.sv ----
// program counter, holding latches, return stack control and fast shadows behind an APB slave
//
// The register addresses and the APB register port are this design's own decisions.
`include "prs_regs.svh"
`default_nettype none
module prs_top
    import prs_pkg::*;
#(
    parameter int MEM_BYTES = 65536,
    parameter int DEPTH = `PRS_STACK_DEPTH
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // instruction execution side
    input wire logic op_valid,
    input wire prs_op_t op_code,
    input wire logic op_fast,
    input wire prs_addr_t op_target,
    input wire logic [7:0] status_in,
    input wire logic [7:0] working_register_in,
    input wire logic [7:0] bank_select_register_in,
    output logic restore_valid,
    output logic [7:0] status_out,
    output logic [7:0] working_register_out,
    output logic [7:0] bank_select_register_out,
    // program memory side
    output prs_addr_t fetch_addr,
    input wire logic [7:0] fetch_rdata,
    output logic [7:0] fetch_data,
    // device reset request
    output logic device_reset
);
    // --------
    // state
    // --------
    prs_addr_t pc;
    logic [7:0] pc_high_holding_latch;
    logic [4:0] pc_upper_holding_latch;
    logic stack_fault_reset_enable;
    logic [7:0] shadow_status;
    logic [7:0] shadow_working;
    logic [7:0] shadow_bank;
    prs_addr_t next_pc;
    logic [31:0] next_rdata;
    logic next_err;

    prs_stack_if sif();

    // --------
    // register decode
    // --------
    function automatic logic [3:0] reg_index(input logic [11:0] addr);
        unique case (addr)
            `PRS_OFS_PC_LOW: reg_index = 4'h1;
            `PRS_OFS_PC_HIGH_LATCH: reg_index = 4'h2;
            `PRS_OFS_PC_UPPER_LATCH: reg_index = 4'h3;
            `PRS_OFS_STACK_PTR: reg_index = 4'h4;
            `PRS_OFS_STACK_TOP_LOW: reg_index = 4'h5;
            `PRS_OFS_STACK_TOP_HIGH: reg_index = 4'h6;
            `PRS_OFS_STACK_TOP_UPPER: reg_index = 4'h7;
            `PRS_OFS_CONTROL: reg_index = 4'h8;
            default: reg_index = 4'h0;
        endcase
    endfunction

    logic [3:0] idx;
    logic access;
    logic wr_acc;
    logic rd_acc;
    logic wr_lane0;

    assign idx = reg_index(paddr);
    // zero wait states: pready is raised by the setup edge, so the access edge completes
    assign access = psel & penable & pready;
    assign wr_acc = access & pwrite;
    assign rd_acc = access & ~pwrite;
    // all registers are at most a byte wide, so only lane zero matters
    assign wr_lane0 = wr_acc & pstrb[0];

    // --------
    // op decode
    // --------
    logic is_op;
    logic op_push;
    logic op_pop;
    logic op_vector;
    logic op_save;
    logic op_restore;

    assign is_op = op_valid & (op_code != PRS_OP_NONE);
    assign op_vector = op_valid & ((op_code == PRS_OP_INT_HIGH) | (op_code == PRS_OP_INT_LOW));
    assign op_push = op_valid & ((op_code == PRS_OP_CALL) | (op_code == PRS_OP_PUSH) | op_vector);
    assign op_pop = op_valid & ((op_code == PRS_OP_RETURN) | (op_code == PRS_OP_RET_LITERAL)
        | (op_code == PRS_OP_RET_INTERRUPT));
    assign op_save = op_vector | (op_valid & (op_code == PRS_OP_CALL) & op_fast);
    assign op_restore = op_valid & op_fast & ((op_code == PRS_OP_RETURN) | (op_code == PRS_OP_RET_INTERRUPT));

    // --------
    // stack control
    // --------
    assign sif.push = op_push;
    assign sif.pop = op_pop;
    assign sif.discard = op_valid & (op_code == PRS_OP_POP);
    // the push that triggers a fault reset records the instruction after it
    assign sif.push_data = (stack_fault_reset_enable & (sif.ptr == 5'(DEPTH - 1)))
        ? pc + `PRS_PC_STEP : pc;
    assign sif.fault_en = stack_fault_reset_enable;
    // software stack writes lose to a core op in the same cycle
    assign sif.ptr_we = wr_lane0 & (idx == 4'h4) & ~is_op;
    assign sif.ptr_wdata = pwdata[7:0];
    assign sif.tos_wdata = pwdata[7:0];
    assign sif.tos_we[0] = wr_lane0 & (idx == 4'h5) & ~is_op;
    assign sif.tos_we[1] = wr_lane0 & (idx == 4'h6) & ~is_op;
    assign sif.tos_we[2] = wr_lane0 & (idx == 4'h7) & ~is_op;

    prs_stack #(
        .DEPTH(DEPTH)
    ) u_stack (
        .pclk(pclk),
        .presetn(presetn),
        .sif(sif)
    );

    // --------
    // next counter value
    // --------
    always_comb
    begin
        next_pc = pc;
        if (is_op)
        begin
            unique case (op_code)
                PRS_OP_SEQ: next_pc = pc + `PRS_PC_STEP;
                PRS_OP_JUMP: next_pc = op_target;
                PRS_OP_CALL: next_pc = op_target;
                PRS_OP_RETURN: next_pc = sif.stack_top_entry;
                PRS_OP_RET_LITERAL: next_pc = sif.stack_top_entry;
                PRS_OP_RET_INTERRUPT: next_pc = sif.stack_top_entry;
                PRS_OP_INT_HIGH: next_pc = `PRS_VEC_INT_HIGH;
                PRS_OP_INT_LOW: next_pc = `PRS_VEC_INT_LOW;
                PRS_OP_PUSH: next_pc = pc + `PRS_PC_STEP;
                PRS_OP_POP: next_pc = pc + `PRS_PC_STEP;
                default: next_pc = pc;
            endcase
        end
        else if (wr_lane0 & (idx == 4'h1))
            next_pc = {pc_upper_holding_latch, pc_high_holding_latch, pwdata[7:0]};
        next_pc[0] = 1'b0;
    end

    // --------
    // program counter
    // --------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pc <= `PRS_VEC_RESET;
        else if (sif.fault)
            pc <= `PRS_VEC_RESET;
        else
            pc <= next_pc;
    end

    // --------
    // holding latches
    // --------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pc_high_holding_latch <= 8'h00;
            pc_upper_holding_latch <= 5'h00;
        end
        else if (sif.fault)
        begin
            pc_high_holding_latch <= 8'h00;
            pc_upper_holding_latch <= 5'h00;
        end
        else if (rd_acc & (idx == 4'h1))
        begin
            pc_high_holding_latch <= pc[15:8];
            pc_upper_holding_latch <= pc[20:16];
        end
        else if (wr_lane0 & (idx == 4'h2))
            pc_high_holding_latch <= pwdata[7:0];
        else if (wr_lane0 & (idx == 4'h3))
            pc_upper_holding_latch <= pwdata[4:0];
    end

    // --------
    // control register
    // --------
    // the fault option survives a fault reset, like a configuration bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stack_fault_reset_enable <= `PRS_CTRL_RESET;
        else if (wr_lane0 & (idx == 4'h8))
            stack_fault_reset_enable <= pwdata[`PRS_CTRL_FAULT_RESET_BIT];
    end

    // --------
    // fast shadows
    // --------
    // one level only: a nested save overwrites the previous one
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shadow_status <= 8'h00;
            shadow_working <= 8'h00;
            shadow_bank <= 8'h00;
        end
        else if (op_save)
        begin
            shadow_status <= status_in;
            shadow_working <= working_register_in;
            shadow_bank <= bank_select_register_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            restore_valid <= 1'b0;
            status_out <= 8'h00;
            working_register_out <= 8'h00;
            bank_select_register_out <= 8'h00;
        end
        else
        begin
            restore_valid <= op_restore;
            if (op_restore)
            begin
                status_out <= shadow_status;
                working_register_out <= shadow_working;
                bank_select_register_out <= shadow_bank;
            end
        end
    end

    // --------
    // fetch path
    // --------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fetch_addr <= `PRS_VEC_RESET;
        else if (sif.fault)
            fetch_addr <= `PRS_VEC_RESET;
        else
            fetch_addr <= next_pc;
    end

    // unimplemented space reads as zeros, which the core runs as a no-operation
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fetch_data <= 8'h00;
        else if (32'(fetch_addr) >= 32'(MEM_BYTES))
            fetch_data <= 8'h00;
        else
            fetch_data <= fetch_rdata;
    end

    // --------
    // device reset request
    // --------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            device_reset <= 1'b0;
        else
            device_reset <= sif.fault;
    end

    // --------
    // apb read data
    // --------
    always_comb
    begin
        next_rdata = 32'h00000000;
        next_err = 1'b0;
        unique case (idx)
            4'h1: next_rdata[7:0] = pc[7:0];
            4'h2: next_rdata[7:0] = pc_high_holding_latch;
            4'h3: next_rdata[4:0] = pc_upper_holding_latch;
            4'h4: next_rdata[7:0] = {sif.full, sif.underflow, 1'b0, sif.ptr};
            4'h5: next_rdata[7:0] = sif.stack_top_entry[7:0];
            4'h6: next_rdata[7:0] = sif.stack_top_entry[15:8];
            4'h7: next_rdata[4:0] = sif.stack_top_entry[20:16];
            4'h8: next_rdata[0] = stack_fault_reset_enable;
            default: next_err = 1'b1;
        endcase
    end

    // --------
    // apb response
    // --------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= psel & ~penable;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else if (psel & ~penable)
        begin
            prdata <= pwrite ? 32'h00000000 : next_rdata;
            pslverr <= next_err;
        end
    end
endmodule
`default_nettype wire

// ---- tb/prs_assertions.sv ----
// concurrent checks on the ports of the program counter unit
`include "prs_regs.svh"
`default_nettype none
module prs_assertions
    import prs_pkg::*;
#(
    parameter int MEM_BYTES = 65536
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // core side
    input wire logic op_valid,
    input wire prs_op_t op_code,
    input wire logic op_fast,
    input wire prs_addr_t op_target,
    input wire logic [7:0] status_in,
    input wire logic [7:0] working_register_in,
    input wire logic [7:0] bank_select_register_in,
    input wire logic restore_valid,
    input wire logic [7:0] status_out,
    input wire logic [7:0] working_register_out,
    input wire logic [7:0] bank_select_register_out,
    // memory side and reset request
    input wire prs_addr_t fetch_addr,
    input wire logic [7:0] fetch_rdata,
    input wire logic [7:0] fetch_data,
    input wire logic device_reset
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic [23:0] saved;
    // mirror of the one-level shadow, taken on every save
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            saved <= 24'h000000;
        else if (op_valid && (op_code == PRS_OP_INT_HIGH || op_code == PRS_OP_INT_LOW
                 || (op_fast && op_code == PRS_OP_CALL)))
            saved <= {status_in, working_register_in, bank_select_register_in};
    sequence s_fast_ret;
        op_valid && op_fast && (op_code == PRS_OP_RETURN || op_code == PRS_OP_RET_INTERRUPT);
    endsequence
    property p_restore_pulse;
        s_fast_ret |=> restore_valid;
    endproperty
    a_restore_pulse: assert property (p_restore_pulse) else $error("no restore after fast return");
    property p_restore_value;
        restore_valid |-> $past(op_valid) && {status_out, working_register_out, bank_select_register_out} == saved;
    endproperty
    a_restore_value: assert property (p_restore_value) else $error("restored values differ");
    property p_step;
        op_valid && op_code == PRS_OP_SEQ |=> fetch_addr == $past(fetch_addr) + `PRS_PC_STEP;
    endproperty
    a_step: assert property (p_step) else $error("sequential step wrong");
    property p_jump;
        op_valid && op_code inside {PRS_OP_JUMP, PRS_OP_CALL} |=>
            device_reset || fetch_addr == ($past(op_target) & 21'h1FFFFE);
    endproperty
    a_jump: assert property (p_jump) else $error("direct load wrong");
    property p_vec_high;
        op_valid && op_code == PRS_OP_INT_HIGH |=> device_reset || fetch_addr == `PRS_VEC_INT_HIGH;
    endproperty
    a_vec_high: assert property (p_vec_high) else $error("high vector wrong");
    property p_vec_low;
        op_valid && op_code == PRS_OP_INT_LOW |=> device_reset || fetch_addr == `PRS_VEC_INT_LOW;
    endproperty
    a_vec_low: assert property (p_vec_low) else $error("low vector wrong");
    property p_fault;
        device_reset |-> fetch_addr == `PRS_VEC_RESET && $past(op_valid);
    endproperty
    a_fault: assert property (p_fault) else $error("fault reset without cause");
    property p_quiet;
        !op_valid |=> !device_reset;
    endproperty
    a_quiet: assert property (p_quiet) else $error("reset request with no op");
    property p_zero_fetch;
        fetch_addr >= MEM_BYTES |=> fetch_data == 8'h00;
    endproperty
    a_zero_fetch: assert property (p_zero_fetch) else $error("fetch beyond memory not zero");
    property p_fetch;
        $past(presetn) && fetch_addr < MEM_BYTES |=> fetch_data == $past(fetch_rdata);
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch data wrong");
endmodule
bind prs_top prs_assertions #(.MEM_BYTES(MEM_BYTES)) u_chk (.pclk, .presetn, .op_valid, .op_code, .op_fast,
    .op_target, .status_in, .working_register_in, .bank_select_register_in, .restore_valid, .status_out,
    .working_register_out, .bank_select_register_out, .fetch_addr, .fetch_rdata, .fetch_data, .device_reset);
`default_nettype wire

// ---- tb/prs_mem_model.sv ----
// program memory stand-in, every byte derived from its address
`default_nettype none
module prs_mem_model
    import prs_pkg::*;
(
    // fetch port
    input wire prs_addr_t fetch_addr,
    output logic [7:0] fetch_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // answers at every address, so zeros above the memory must come from the unit
    assign fetch_rdata = fetch_addr[7:0] ^ {fetch_addr[15:9], 1'b1} ^ 8'h5A;
endmodule
`default_nettype wire

// ---- tb/program_counter_return_stack_tb.sv ----
// self-checking bench for the program counter and return stack unit
`include "prs_regs.svh"
`default_nettype none
module program_counter_return_stack_tb
    import prs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, restore_valid, device_reset, op_valid = 1'b0, op_fast = 1'b0;
    prs_op_t op_code = PRS_OP_NONE;
    prs_addr_t op_target = 21'h000000, fetch_addr, pc, stk [0:31];
    logic [7:0] status_in = 8'h00, working_register_in = 8'h00, bank_select_register_in = 8'h00;
    logic [7:0] status_out, working_register_out, bank_select_register_out, fetch_rdata, fetch_data, lh;
    logic [4:0] lu, idx;
    logic full, unf, en;
    logic [32:0] q_rd [$];
    prs_addr_t q_pc [$];
    int n_fail = 0, checks = 0;
    bit pend = 1'b0;
    always #10 pclk = ~pclk;
    prs_top #(.MEM_BYTES(256)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .op_valid, .op_code, .op_fast, .op_target, .status_in, .working_register_in,
        .bank_select_register_in, .restore_valid, .status_out, .working_register_out, .bank_select_register_out,
        .fetch_addr, .fetch_rdata, .fetch_data, .device_reset);
    prs_mem_model u_mem (.fetch_addr, .fetch_rdata);
    // --------
    // comparison, verdict and monitor
    // --------
    task automatic cmp_bus(input logic [32:0] exp, input logic [32:0] got);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value bus expected %h seen %h", exp, got);
        end
    endtask
    task automatic cmp_pc(input prs_addr_t exp, input prs_addr_t got);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value pc expected %h seen %h", exp, got);
        end
    endtask
    task automatic print_verdict;
        if (n_fail == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        if (pend)
            cmp_pc(q_pc.pop_front(), fetch_addr);
        pend = op_valid;
        if (psel && penable && pready)
            cmp_bus(q_rd.pop_front(), {pslverr, prdata});
    end
    initial
    begin
        #100000;
        n_fail++;
        print_verdict;
    end
    // --------
    // reference model and drivers
    // --------
    function automatic logic [7:0] rdv(input logic [11:0] a);
        case (a)
            12'h000: return pc[7:0];
            12'h004: return lh;
            12'h008: return {3'h0, lu};
            12'h00C: return {full, unf, 1'b0, idx};
            12'h010: return stk[idx][7:0];
            12'h014: return stk[idx][15:8];
            12'h018: return {3'h0, stk[idx][20:16]};
            12'h01C: return {7'h00, en};
            default: return 8'h00;
        endcase
    endfunction
    task automatic push(input prs_addr_t v);
        if (idx < 5'd30)
        begin
            idx++;
            stk[idx] = v;
        end
        else
        begin
            full = 1'b1;
            if (idx == 5'd30 && en)
            begin
                stk[31] = v + `PRS_PC_STEP;
                {pc, idx, lh, lu} = '0;
            end
            else if (idx == 5'd30)
            begin
                stk[31] = v;
                idx = 5'd31;
            end
        end
    endtask
    task automatic op(input prs_op_t c, input prs_addr_t t = 21'h000000, input logic f = 1'b0);
        prs_addr_t v;
        @(posedge pclk);
        op_valid <= 1'b1;
        op_code <= c;
        op_target <= t;
        op_fast <= f;
        status_in <= 8'($urandom);
        working_register_in <= 8'($urandom);
        bank_select_register_in <= 8'($urandom);
        v = pc;
        case (c)
            PRS_OP_SEQ: pc = pc + `PRS_PC_STEP;
            PRS_OP_JUMP: pc = t & 21'h1FFFFE;
            PRS_OP_POP:
            begin
                pc = pc + `PRS_PC_STEP;
                idx = idx - 5'd1;
            end
            PRS_OP_CALL, PRS_OP_INT_HIGH, PRS_OP_INT_LOW, PRS_OP_PUSH:
            begin
                pc = c == PRS_OP_CALL ? t & 21'h1FFFFE : c == PRS_OP_PUSH ? pc + `PRS_PC_STEP :
                    c == PRS_OP_INT_HIGH ? `PRS_VEC_INT_HIGH : `PRS_VEC_INT_LOW;
                push(v);
            end
            default:
                if (idx == 5'd0)
                begin
                    pc = 21'h000000;
                    unf = 1'b1;
                    if (en)
                        {pc, idx, lh, lu} = '0;
                end
                else
                begin
                    pc = stk[idx];
                    idx--;
                end
        endcase
        q_pc.push_back(pc);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d = 8'h00);
        q_rd.push_back({a > 12'h01C || a[1:0] != 2'b00, 24'h000000, w ? 8'h00 : rdv(a)});
        if (!w && a == 12'h000)
            {lu, lh} = pc[20:8];
        if (w)
            case (a)
                12'h000: pc = {lu, lh, d[7:1], 1'b0};
                12'h004: lh = d;
                12'h008: lu = d[4:0];
                12'h00C: {full, unf, idx} = {full & d[7], unf & d[6], d[4:0]};
                12'h010: if (idx != 5'd0) stk[idx][7:0] = d;
                12'h014: if (idx != 5'd0) stk[idx][15:8] = d;
                12'h018: if (idx != 5'd0) stk[idx][20:16] = d[4:0];
                12'h01C: en = d[0];
                default: ;
            endcase
        @(posedge pclk);
        op_valid <= 1'b0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic reset_dut(input int n);
        presetn <= 1'b0;
        repeat (n) @(posedge pclk);
        presetn <= 1'b1;
        {pc, idx, lh, lu, full, unf, en} = {41'h0, 1'b1};
    endtask
    // --------
    // main sequence
    // --------
    initial
    begin
        foreach (stk[i])
            stk[i] = 21'h000000;
        void'($urandom(56));
        reset_dut(3);
        apb(0, 12'h00C);
        apb(0, 12'h01C);
        apb(0, 12'h020);
        apb(1, 12'h024, 8'hFF);
        op(PRS_OP_SEQ);
        op(PRS_OP_JUMP, 21'($urandom) | 21'h000001);
        apb(1, 12'h004, 8'($urandom));
        apb(1, 12'h008, 8'($urandom));
        op(PRS_OP_CALL, 21'($urandom));
        op(PRS_OP_RETURN);
        apb(0, 12'h004);
        apb(0, 12'h000);
        apb(0, 12'h004);
        apb(0, 12'h008);
        apb(1, 12'h004, 8'h12);
        apb(1, 12'h000, 8'h35);
        op(PRS_OP_SEQ);
        op(PRS_OP_INT_HIGH);
        op(PRS_OP_CALL, 21'($urandom), 1'b1);
        op(PRS_OP_INT_LOW);
        op(PRS_OP_PUSH);
        op(PRS_OP_POP);
        for (int a = 12'h00C; a <= 12'h018; a += 4)
            apb(0, 12'(a));
        apb(1, 12'h010, 8'h5C);
        apb(1, 12'h018, 8'h1F);
        op(PRS_OP_RET_INTERRUPT, 21'h000000, 1'b1);
        op(PRS_OP_RETURN, 21'h000000, 1'b1);
        op(PRS_OP_RET_LITERAL);
        apb(1, 12'h01C, 8'h00);
        repeat (30) op(PRS_OP_PUSH);
        apb(0, 12'h00C);
        op(PRS_OP_PUSH);
        op(PRS_OP_PUSH);
        apb(0, 12'h00C);
        apb(0, 12'h010);
        apb(1, 12'h00C, 8'hC0);
        apb(0, 12'h00C);
        op(PRS_OP_RETURN);
        apb(0, 12'h00C);
        apb(0, 12'h004);
        apb(1, 12'h00C, 8'h1E);
        apb(1, 12'h01C, 8'h01);
        op(PRS_OP_CALL, 21'($urandom));
        apb(0, 12'h00C);
        apb(0, 12'h004);
        apb(1, 12'h00C, 8'h9F);
        apb(0, 12'h010);
        op(PRS_OP_RETURN);
        apb(1, 12'h004, 8'hA5);
        apb(1, 12'h00C, 8'h00);
        op(PRS_OP_RETURN);
        apb(0, 12'h004);
        apb(0, 12'h00C);
        reset_dut(2);
        apb(0, 12'h00C);
        op(PRS_OP_SEQ);
        apb(0, 12'h01C);
        @(posedge pclk);
        print_verdict;
    end
endmodule
`default_nettype wire
